// >>> src/scd_pkg.sv
// Function
// - Phase bit 5 and polarity bit 4 of configuration give four clock modes.
// - Phase 0 centres data on first clock edge; phase 1 on second.
// - Polarity 0 idles the clock low; polarity 1 idles it high.
// - Master and slave must share phase and polarity before exchanging data.
// - Clock-rate setting applies only in master role; ignored as slave.
// - Master rate never above half system clock or 12.5 MHz.
// - Receive-only slave with synchronous inputs accepts up to 1/4 clock.
// - Busy flag bit 7 reads 1 while any transfer is in progress; as slave the code sets it only from the first to the eighth sample.
// - Bit 6 selects role: 0 slave, 1 master.
// - Bit 3 reads 1 while deglitched slave select is low.
// - Bit 2 returns the undeglitched select pin level at read time.
// - Shift-empty bit 1 sets after byte with nothing pending; master reads 1.
// - Receive-empty bit 0 is 1 after read, 0 with unread data; master role reads 1 always.
// - Data write loads transmit buffer; in master role it starts transfer.
// - Data read returns the receive buffer.
// - Slave samples mid-bit; master samples one clock before bit end.
//
// Purpose: Constants shared by the serial port design
// Assumes: 100 MHz system clock
// Notes:   Register offsets are the special-function addresses
package scd_pkg;
    // ======================================================
    // Register map
    localparam logic [7:0] CFG_ADDR = 8'ha1;
    localparam logic [7:0] DAT_ADDR = 8'ha3;
    localparam logic [7:0] CFG_RESET = 8'h07;
    localparam logic [7:0] DAT_RESET = 8'h00;
    localparam int BUSY_BIT = 7;
    localparam int MASTER_BIT = 6;
    localparam int PHASE_BIT = 5;
    localparam int POL_BIT = 4;
    localparam int SEL_BIT = 3;
    localparam int PIN_BIT = 2;
    localparam int SHIFT_REGISTER_EMPTY_BIT = 1;
    localparam int RECEIVE_BUFFER_EMPTY_BIT = 0;

    // ======================================================
    // Timing
    localparam int SYS_PERIOD_NS = 10;
    localparam int MIN_SCK_PERIOD_NS = 80;
    // Least half period, rounded up to whole cycles
    localparam int MIN_HALF_CYC =
        (MIN_SCK_PERIOD_NS + 2 * SYS_PERIOD_NS - 1) / (2 * SYS_PERIOD_NS);
    localparam int BYTE_BITS = 8;
    localparam int TX_DEPTH = 16;

    // ======================================================
    // Master engine states
    typedef enum logic [0:0] {
        SCD_M_IDLE = 1'b0,
        SCD_M_RUN = 1'b1
    } scd_mstate_t;
endpackage : scd_pkg

// >>> src/scd_port.sv
// Purpose: Serial port with configuration, data buffer and shift engines
// Assumes: Link pins are asynchronous and pass two flops before use
// Notes:   Transmit data waits in a small FIFO; writes when full are lost
`timescale 1ns/1ps

// ======================================================
// Transmit FIFO
module scd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    if (DEPTH < 2 || (1 << AW) != DEPTH)
        $error("scd_fifo depth must be a power of two");

    // Honest flags straight from the occupancy count
    assign in_ready = cnt_q != DEPTH[AW:0];
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rp_q];

    // Storage array, no reset needed on data
    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wp_q] <= in_data;
    end

    // Pointers and count
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule : scd_fifo

// ======================================================
// Port top
module scd_port #(
    parameter int TX_DEPTH = scd_pkg::TX_DEPTH
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic port_enable,
    input wire logic [7:0] clock_rate,
    output logic tx_buf_ready,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic slave_select_pin_n
);
    // ======================================================
    // Pin synchronisers: stage one feeds only stage two
    logic [1:0] sck_m_q;
    logic [1:0] mosi_m_q;
    logic [1:0] miso_m_q;
    logic [1:0] nss_m_q;
    logic sck_p_q;
    logic nss_h1_q;
    logic nss_h2_q;
    logic nss_dg_q;
    wire sck_s = sck_m_q[1];
    wire mosi_s = mosi_m_q[1];
    wire miso_s = miso_m_q[1];
    wire nss_s = nss_m_q[1];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sck_m_q <= '0;
            mosi_m_q <= '0;
            miso_m_q <= '0;
            nss_m_q <= 2'h3;
        end
        else
        begin
            sck_m_q <= {sck_m_q[0], sck_i};
            mosi_m_q <= {mosi_m_q[0], mosi_i};
            miso_m_q <= {miso_m_q[0], miso_i};
            nss_m_q <= {nss_m_q[0], slave_select_pin_n};
        end
    end

    // select deglitch: three equal samples in a row move the copy
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nss_h1_q <= 1'b1;
            nss_h2_q <= 1'b1;
            nss_dg_q <= 1'b1;
            sck_p_q <= 1'b0;
        end
        else
        begin
            nss_h1_q <= nss_s;
            nss_h2_q <= nss_h1_q;
            sck_p_q <= sck_s;
            if (nss_s == nss_h1_q && nss_h1_q == nss_h2_q)
                nss_dg_q <= nss_s;
        end
    end

    // ======================================================
    // Configuration state and shared wires
    logic master_q;
    logic cpha_q;
    logic cpol_q;
    logic [7:0] rx_q;
    logic rxb_q;
    logic fifo_valid;
    logic [7:0] fifo_data;
    wire cfg_wr = sfr_wr && sfr_addr == scd_pkg::CFG_ADDR;
    wire dat_wr = sfr_wr && sfr_addr == scd_pkg::DAT_ADDR;
    wire cfg_rd = sfr_rd && sfr_addr == scd_pkg::CFG_ADDR;
    wire dat_rd = sfr_rd && sfr_addr == scd_pkg::DAT_ADDR;
    wire m_en = port_enable && master_q;
    wire s_sel = port_enable && !master_q && !nss_dg_q;

    // ======================================================
    // Master engine: 16 half periods per byte
    scd_pkg::scd_mstate_t m_st_q;
    logic [3:0] half_q;
    logic [8:0] hcnt_q;
    logic [7:0] m_sh_q;
    logic [7:0] m_rx_q;
    wire m_run = m_st_q == scd_pkg::SCD_M_RUN;
    wire m_start = m_en && !m_run && fifo_valid;
    wire [8:0] rate_half = {1'b0, clock_rate} + 9'h001;
    // rate clamp: never shorter than the least half period
    // rate ignored as slave: only the master engine reads it
    wire [8:0] half_len = (rate_half < 9'(scd_pkg::MIN_HALF_CYC)) ?
        9'(scd_pkg::MIN_HALF_CYC) : rate_half;
    wire half_end = m_run && hcnt_q == half_len - 9'h001;
    // master sampling on the last cycle of each bit
    wire m_sample = half_end && half_q[0];
    wire m_done = half_end && half_q == 4'hf;
    wire [7:0] m_rx_next = {m_rx_q[6:0], miso_s};

    // phase: odd halves end each bit for either phase setting
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            m_st_q <= scd_pkg::SCD_M_IDLE;
            half_q <= '0;
            hcnt_q <= '0;
            m_sh_q <= '0;
            m_rx_q <= '0;
        end
        else if (!m_en)
        begin
            m_st_q <= scd_pkg::SCD_M_IDLE;
            half_q <= '0;
            hcnt_q <= '0;
        end
        else
        begin
            unique case (m_st_q)
                scd_pkg::SCD_M_IDLE:
                begin
                    hcnt_q <= '0;
                    half_q <= '0;
                    // master start: a written byte starts the transfer
                    if (m_start)
                    begin
                        m_sh_q <= fifo_data;
                        m_st_q <= scd_pkg::SCD_M_RUN;
                    end
                end
                scd_pkg::SCD_M_RUN:
                begin
                    hcnt_q <= half_end ? 9'h000 : hcnt_q + 9'h001;
                    if (half_end)
                        half_q <= half_q + 4'h1;
                    if (m_sample)
                        m_rx_q <= m_rx_next;
                    // msb first: next bit moves up at each bit end
                    if (m_sample)
                        m_sh_q <= {m_sh_q[6:0], 1'b0};
                    if (m_done)
                        m_st_q <= scd_pkg::SCD_M_IDLE;
                end
            endcase
        end
    end

    // idle level and mode: clock follows polarity, phase and half
    assign sck_o = m_run ? (cpol_q ^ cpha_q ^ half_q[0]) : cpol_q;
    assign mosi_o = m_sh_q[7];
    // role select: only the chosen role drives its pins
    assign sck_oe = m_en;
    assign mosi_oe = m_en;
    assign miso_oe = s_sel;

    // ======================================================
    // Slave engine: edges found on the sampled link clock
    // slave rate: two sync flops plus edge find need four clocks a bit
    logic [2:0] s_cnt_q;
    logic [7:0] s_rx_q;
    logic [7:0] tx_sh_q;
    logic loaded_q;
    logic out_q;
    logic shift_register_empty_q;
    wire s_edge = s_sel && (sck_s ^ sck_p_q);
    wire s_lead = s_edge && (sck_s != cpol_q);
    // slave sampling on the edge that sits mid-bit
    wire s_samp = cpha_q ? (s_edge && !s_lead) : s_lead;
    wire s_shft = s_edge && !s_samp;
    // mode shared: edges are decoded with the port's own phase and polarity bits
    // Phase 0 trailing edge after the eighth sample closes the old byte
    wire s_tail = s_shft && !cpha_q && s_cnt_q == 3'h0;
    wire s_done = s_samp && s_cnt_q == 3'h7;
    wire s_idle_load = !loaded_q && s_cnt_q == 3'h0 && !s_edge;
    wire s_load = s_sel && fifo_valid && (s_done || s_idle_load);
    wire [7:0] s_rx_next = {s_rx_q[6:0], mosi_s};
    assign miso_o = out_q;

    // Bit counter and receive shifter
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_cnt_q <= '0;
            s_rx_q <= '0;
        end
        else if (!s_sel)
            s_cnt_q <= '0;
        else if (s_samp)
        begin
            s_cnt_q <= s_cnt_q + 3'h1;
            s_rx_q <= s_rx_next;
        end
    end

    // Transmit byte held still; the counter picks the bit
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_sh_q <= '0;
            loaded_q <= 1'b0;
            out_q <= 1'b0;
        end
        else
        begin
            if (s_load)
                tx_sh_q <= fifo_data;
            if (s_load)
                loaded_q <= 1'b1;
            else if (s_done)
                loaded_q <= 1'b0;
            // msb first out of the slave
            if (s_load && !s_done)
                out_q <= fifo_data[7];
            else if (s_shft)
                out_q <= tx_sh_q[~s_cnt_q];
        end
    end

    // shift empty: byte end sets and wins over the clock-edge clear
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            shift_register_empty_q <= 1'b1;
        else if (s_load)
            shift_register_empty_q <= 1'b0;
        else if (s_done)
            shift_register_empty_q <= 1'b1;
        else if (s_edge && !s_tail)
            shift_register_empty_q <= 1'b0;
    end

    // ======================================================
    // Transmit buffer
    scd_fifo #(
        .WIDTH(scd_pkg::BYTE_BITS),
        .DEPTH(TX_DEPTH)
    ) u_txf (
        .clk(mclk),
        .arst_n(arst_n),
        .in_valid(dat_wr),
        .in_ready(tx_buf_ready),
        .in_data(sfr_wdata),
        .out_valid(fifo_valid),
        .out_ready(m_start || s_load),
        .out_data(fifo_data)
    );

    // ======================================================
    // Registers and read port
    wire byte_done = m_done || s_done;
    wire busy = m_run || (s_sel && s_cnt_q != 3'h0);
    wire shift_register_empty_rd = master_q ? 1'b1 : shift_register_empty_q;
    wire rxb_rd = master_q ? 1'b1 : rxb_q;
    // raw pin: the synced level, no deglitch
    wire [7:0] cfg_val = {busy, master_q, cpha_q, cpol_q, !nss_dg_q,
        nss_s, shift_register_empty_rd, rxb_rd};

    // Configuration writes and receive buffer
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            master_q <= scd_pkg::CFG_RESET[scd_pkg::MASTER_BIT];
            cpha_q <= scd_pkg::CFG_RESET[scd_pkg::PHASE_BIT];
            cpol_q <= scd_pkg::CFG_RESET[scd_pkg::POL_BIT];
            rx_q <= scd_pkg::DAT_RESET;
            rxb_q <= scd_pkg::CFG_RESET[scd_pkg::RECEIVE_BUFFER_EMPTY_BIT];
        end
        else
        begin
            // role and mode bits written by software
            if (cfg_wr)
            begin
                master_q <= sfr_wdata[scd_pkg::MASTER_BIT];
                cpha_q <= sfr_wdata[scd_pkg::PHASE_BIT];
                cpol_q <= sfr_wdata[scd_pkg::POL_BIT];
            end
            if (byte_done)
                rx_q <= m_done ? m_rx_next : s_rx_next;
            // receive empty: new data wins over a read
            if (byte_done)
                rxb_q <= 1'b0;
            else if (dat_rd)
                rxb_q <= 1'b1;
        end
    end

    // read data register; unmapped reads return zero
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            sfr_rdata <= '0;
        else if (cfg_rd)
            sfr_rdata <= cfg_val;
        else if (dat_rd)
            sfr_rdata <= rx_q;
        else if (sfr_rd)
            sfr_rdata <= '0;
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    chk_mode_bits_write: assert property (
        cfg_wr |=> cpha_q == $past(sfr_wdata[5]) &&
            cpol_q == $past(sfr_wdata[4]))
        else $error("Phase or polarity not taken from write");
    chk_phase_data_centre: assert property (
        m_run && $past(m_run) && half_q[0] && $changed(sck_o) |->
            $stable(mosi_o))
        else $error("Data moved on a clock edge");
    chk_idle_clock_level: assert property (
        m_en && !m_run |-> sck_o == cpol_q)
        else $error("Clock not at idle level");
    chk_slave_no_drive: assert property (
        !master_q |-> !sck_oe && !mosi_oe)
        else $error("Slave drives the link clock");
    chk_rate_half_min: assert property (
        m_run && $changed(sck_o) |=> $stable(sck_o)[*3])
        else $error("Master clock faster than allowed");
    chk_busy_after_start: assert property (
        m_start |=> busy ##1 cfg_rd |=> sfr_rdata[7])
        else $error("Busy flag not set during transfer");
    chk_role_pins: assert property (
        m_en |-> mosi_oe && !miso_oe)
        else $error("Master role pins wrong");
    chk_sel_deglitch: assert property (
        (!nss_s)[*3] |=> !nss_dg_q)
        else $error("Deglitched select did not follow pin");
    chk_shift_register_empty_master_one: assert property (
        master_q && cfg_rd |=> sfr_rdata[1] && sfr_rdata[0])
        else $error("Empty flags not one in master role");
    chk_rxb_cleared: assert property (
        s_done |=> !rxb_q)
        else $error("Receive empty stayed set after a byte");
    chk_write_starts: assert property (
        dat_wr && m_en && !m_run && !fifo_valid |-> ##[1:2] m_run)
        else $error("Data write did not start master transfer");
    chk_data_read: assert property (
        dat_rd |=> sfr_rdata == $past(rx_q))
        else $error("Data read did not return receive buffer");
    chk_master_sample_end: assert property (
        m_sample && !m_done |=> $changed(sck_o))
        else $error("Master sample not on last bit cycle");
    chk_msb_first_out: assert property (
        m_start |=> mosi_o == $past(fifo_data[7]))
        else $error("First bit out is not the msb");

    cov_master_byte: cover property (m_done);
    cov_slave_byte: cover property (s_done && cpha_q);
    cov_fifo_full: cover property (!tx_buf_ready);
    cov_phase_one_master: cover property (m_done && cpha_q && cpol_q);
endmodule : scd_port

// >>> bench/scd_partner.sv
// Purpose: Far-side link model, acting as slave or master
// Assumes: Mode bits are set to match the port before traffic
// Notes:   Master side runs 120 ns bits, unrelated to mclk
`timescale 1ns/1ps
module scd_partner (
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic act_master,
    input wire logic load,
    input wire logic [15:0] ld_data,
    output logic p_sck,
    output logic p_mosi,
    output logic p_miso,
    output logic ss_n,
    output logic [15:0] s_rx,
    output int cnt
);
    logic [15:0] s_tx;
    logic lead;

    // Idle levels at time zero
    initial
    begin
        p_sck = 1'b0;
        p_mosi = 1'b0;
        p_miso = 1'b0;
        ss_n = 1'b1;
        cnt = 0;
    end

    always @(posedge load)
    begin
        s_tx = ld_data;
        cnt = 0;
        p_miso = ld_data[15];
    end

    always @(sck)
    begin
        lead = (sck != cpol);
        if (!act_master && (lead ^ cpha))
        begin
            s_rx = {s_rx[14:0], mosi};
            cnt = cnt + 1;
        end
        else if (!act_master && (!cpha || cnt > 0))
        begin
            s_tx = s_tx << 1;
            p_miso = s_tx[15];
        end
    end

    // Unused line keeps moving so stale data never looks valid
    always #10 if (act_master) p_miso = ~p_miso;

    task sel();
        p_sck = cpol;
        ss_n = 1'b0;
        #153;
    endtask : sel

    // master frame; capture mid-half for settling margin
    // asynchronous bits of 120 ns stay below a tenth of mclk
    task xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            if (!cpha)
                p_mosi = tx[i];
            #40 p_sck = ~cpol;
            if (cpha)
                p_mosi = tx[i];
            #20 if (!cpha) rx = {rx[6:0], miso};
            #20 p_sck = cpol;
            #20 if (cpha) rx = {rx[6:0], miso};
            #20;
        end
    endtask : xfer

    task desel();
        ss_n = 1'b1;
        p_mosi = ~p_mosi;
    endtask : desel
endmodule : scd_partner

// >>> bench/scd_port_tb.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Partner model on the far side of the link
// Notes:   Register reads are checked from a queue of notes
`timescale 1ns/1ps
module scd_port_tb;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic port_enable = 1'b0;
    logic [7:0] clock_rate = 8'h00;
    logic [7:0] sfr_rdata;
    logic tx_buf_ready, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    logic act_master = 1'b0;
    logic load = 1'b0;
    logic [15:0] ld_data = 16'h0000;
    logic p_sck, p_mosi, p_miso, ss_n;
    logic [15:0] s_rx;
    int cnt;
    logic [31:0] seed = 32'hef15;
    logic [15:0] rq[$];
    logic [15:0] note;
    logic rd_seen = 1'b0;
    int fails = 0;
    int tests_run = 0;
    wire sck_w = sck_oe ? sck_o : p_sck;
    wire mosi_w = mosi_oe ? mosi_o : p_mosi;
    wire miso_w = miso_oe ? miso_o : p_miso;

    always #5 mclk = ~mclk;

    scd_port #(.TX_DEPTH(16)) dut (.mclk(mclk), .arst_n(arst_n),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .port_enable(port_enable), .clock_rate(clock_rate),
        .tx_buf_ready(tx_buf_ready), .sck_i(sck_w), .sck_o(sck_o),
        .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe(miso_oe), .slave_select_pin_n(ss_n));

    scd_partner p (.sck(sck_w), .mosi(mosi_w), .miso(miso_w),
        .cpol(cpol), .cpha(cpha), .act_master(act_master), .load(load),
        .ld_data(ld_data), .p_sck(p_sck), .p_mosi(p_mosi),
        .p_miso(p_miso), .ss_n(ss_n), .s_rx(s_rx), .cnt(cnt));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task stop_test();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    task chk(input logic [7:0] got, input logic [7:0] exp,
             input logic [7:0] mask);
        tests_run++;
        if (((got ^ exp) & mask) !== 8'h00)
        begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge mclk);
        sfr_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        rq.push_back({e, m});
        @(posedge mclk);
        sfr_rd <= 1'b0;
    endtask : rd

    // port held off while the mode changes
    task cfg(input logic [7:0] v, input logic en);
        @(posedge mclk);
        port_enable <= 1'b0;
        cpol <= v[4];
        cpha <= v[5];
        wr(scd_pkg::CFG_ADDR, v);
        port_enable <= en;
    endtask : cfg

    task pload(input logic [15:0] v);
        ld_data <= v;
        load <= 1'b1;
        @(posedge mclk);
        load <= 1'b0;
    endtask : pload

    task wait_cnt(input int n);
        int i;
        i = 0;
        while (cnt < n && i < 5000)
        begin
            @(posedge mclk);
            i++;
        end
        if (cnt < n)
        begin
            fails++;
            $display("wrong value at %0t: link stalled", $time);
            stop_test();
        end
    endtask : wait_cnt

    // Oldest read note against the byte returned one cycle later
    always @(posedge mclk)
    begin
        if (rd_seen)
        begin
            note = rq.pop_front();
            chk(sfr_rdata, note[15:8], note[7:0]);
        end
        rd_seen <= sfr_rd;
    end

    // ==========================================================
    // Scenarios
    task do_master(input logic [1:0] m);
        logic [31:0] d;
        seed = lfsr(seed);
        d = seed;
        clock_rate <= {5'h00, d[10:8]};
        act_master <= 1'b0;
        cfg({2'b01, m, 4'h0}, 1'b1);
        repeat (3) @(posedge mclk);
        chk({7'h00, sck_w}, {7'h00, m[0]}, 8'h01);
        pload(d[15:0]);
        wr(scd_pkg::DAT_ADDR, d[23:16]);
        wr(scd_pkg::DAT_ADDR, d[31:24]);
        rd(scd_pkg::CFG_ADDR, {2'b11, m, 4'h7}, 8'hff);
        wait_cnt(16);
        repeat (12) @(posedge mclk);
        chk(s_rx[15:8], d[23:16], 8'hff);
        chk(s_rx[7:0], d[31:24], 8'hff);
        rd(scd_pkg::DAT_ADDR, d[7:0], 8'hff);
        rd(scd_pkg::CFG_ADDR, {2'b01, m, 4'h7}, 8'hff);
    endtask : do_master

    task do_slave(input logic [1:0] m);
        logic [31:0] d;
        logic [7:0] r;
        seed = lfsr(seed);
        d = seed;
        clock_rate <= d[7:0];
        act_master <= 1'b1;
        cfg({2'b00, m, 4'h0}, 1'b1);
        wr(scd_pkg::DAT_ADDR, d[15:8]);
        repeat (4) @(posedge mclk);
        p.sel();
        rd(scd_pkg::CFG_ADDR, {2'b00, m, 4'h8}, 8'hfe);
        p.xfer(d[23:16], r);
        chk(r, d[15:8], 8'hff);
        repeat (6) @(posedge mclk);
        rd(scd_pkg::CFG_ADDR, {2'b00, m, 4'ha}, 8'hff);
        rd(scd_pkg::DAT_ADDR, d[23:16], 8'hff);
        rd(scd_pkg::CFG_ADDR, {2'b00, m, 4'hb}, 8'hff);
        p.desel();
        repeat (8) @(posedge mclk);
        rd(scd_pkg::CFG_ADDR, {2'b00, m, 4'h7}, 8'hfd);
    endtask : do_slave

    // Fill while disabled, refuse one more, then drain at top rate
    task fill_drain();
        act_master <= 1'b0;
        clock_rate <= 8'h00;
        cfg(8'h40, 1'b0);
        pload(16'h0000);
        for (int k = 0; k < 16; k++)
            wr(scd_pkg::DAT_ADDR, 8'h10 + k[7:0]);
        @(posedge mclk);
        chk({7'h00, tx_buf_ready}, 8'h00, 8'h01);
        wr(scd_pkg::DAT_ADDR, 8'hee);
        port_enable <= 1'b1;
        wait_cnt(128);
        repeat (200) @(posedge mclk);
        chk(cnt[7:0], 8'h80, 8'hff);
        chk(s_rx[7:0], 8'h1f, 8'hff);
        chk({7'h00, tx_buf_ready}, 8'h01, 8'h01);
    endtask : fill_drain

    // Main sequence
    initial
    begin
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(scd_pkg::CFG_ADDR, 8'h07, 8'hff);
        rd(scd_pkg::DAT_ADDR, 8'h00, 8'hff);
        rd(8'h55, 8'h00, 8'hff);
        wr(scd_pkg::CFG_ADDR, 8'hff);
        rd(scd_pkg::CFG_ADDR, 8'h77, 8'hff);
        wr(8'h55, 8'h00);
        rd(scd_pkg::CFG_ADDR, 8'h77, 8'hff);
        for (int m = 0; m < 4; m++)
            do_master(m[1:0]);
        fill_drain();
        for (int m = 0; m < 4; m++)
            do_slave(m[1:0]);
        repeat (10) @(posedge mclk);
        stop_test();
    end
endmodule : scd_port_tb
